// *** pkg/touch_regs.vh ***
`ifndef TOUCH_CTRL_REGS_VH
`define TOUCH_CTRL_REGS_VH

// serial command layout after the start bit, msb first
`define CMD_BITS        3'd7
`define CMD_LAST        3'd6
`define CMD_CHAN_HI     6
`define CMD_CHAN_LO     4
`define CMD_MODE_8BIT   3
`define CMD_REF_SE      2
`define CMD_REF_PWR     1
`define CMD_PD_CTRL     0

// acquisition length in conversion clocks
`define ACQ_LAST        3'd2

// result resolution
`define RES_BITS        12
`define SAR_MSB         4'd11
`define SAR_LSB_12      4'd0
`define SAR_LSB_8       4'd4
`define SAR_TRIAL       12'h800
`define SAR_ZERO        12'h000

// channel codes
`define CH_TEMP_LOW     3'h0
`define CH_Y_POS        3'h1
`define CH_BATTERY      3'h2
`define CH_Z1           3'h3
`define CH_Z2           3'h4
`define CH_X_POS        3'h5
`define CH_AUX          3'h6
`define CH_TEMP_HIGH    3'h7

// reference source: vref pin/gnd, or pairs of panel terminals
`define REF_VREF_PIN    2'h0
`define REF_YP_YN       2'h1
`define REF_YP_XN       2'h2
`define REF_XP_XN       2'h3

// sequencer states
`define ST_IDLE         2'h0
`define ST_CMD          2'h1
`define ST_ACQ          2'h2
`define ST_CONV         2'h3

// reset values
`define CMD_RESET       7'h00
`define CNT_RESET       3'h0

`endif

// *** rtl/pin_sync.v ***
`timescale 1ns/1ps
// two-stage synchroniser for asynchronous pin levels
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// *** rtl/touch_adc_mux_control.v ***
`timescale 1ns/1ps
`include "touch_regs.vh"

module touch_adc_mux_control (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        conversion_clock,
  input  wire        cs_n,
  input  wire        din,
  input  wire        comp_in,
  output reg         dout,
  output reg         dout_oe,
  output reg         busy,
  output reg         busy_oe,
  output reg  [2:0]  mux_sel,
  output reg  [1:0]  ref_sel,
  output reg         drv_xp,
  output reg         drv_xn,
  output reg         drv_yp,
  output reg         drv_yn,
  output reg         diode_temp_low_bias,
  output reg         diode_temp_high_bias,
  output reg         bat_div_en,
  output reg         internal_ref_power,
  output reg         adc_power_down,
  output reg         sample_en,
  output reg  [11:0] dac_code,
  output reg  [11:0] result,
  output reg         result_valid
);
  wire [3:0] sync_w;
  wire       clk_s;
  wire       csn_s;
  wire       din_s;
  wire       comp_s;
  reg        clk_d_r;
  wire       rise;
  wire       fall;

  reg  [1:0]  st_r;
  reg  [2:0]  cnt_r;
  reg  [6:0]  cmd_r;
  wire [6:0]  cmd_nxt;
  reg  [2:0]  chan_r;
  reg         se_r;
  reg         mode8_r;
  reg         pd0_r;
  reg  [3:0]  idx_r;
  wire [3:0]  lsb_idx;

  reg  [2:0]  mux_nxt;
  reg  [1:0]  ref_nxt;
  reg         xp_nxt;
  reg         xn_nxt;
  reg         yp_nxt;
  reg         yn_nxt;
  reg         drv_on;
  reg         acq_on;

  // every pin is asynchronous to core_clk
  pin_sync #(
    .WIDTH    (4)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({comp_in, din, ~cs_n, conversion_clock}),
    .sync_out (sync_w)
  );

  assign clk_s   = sync_w[0];
  // select is synced active high so reset reads as deselected
  assign csn_s   = ~sync_w[1];
  assign din_s   = sync_w[2];
  assign comp_s  = sync_w[3];
  assign rise    = clk_s & ~clk_d_r;
  assign fall    = ~clk_s & clk_d_r;
  assign cmd_nxt = {cmd_r[5:0], din_s};
  assign lsb_idx = mode8_r ? `SAR_LSB_8 : `SAR_LSB_12;

  // panel switch and mux decode from the latched command
  always @* begin
    drv_on  = (st_r == `ST_ACQ) || (st_r == `ST_CONV) || pd0_r;
    acq_on  = (st_r == `ST_ACQ);
    mux_nxt = chan_r;
    ref_nxt = `REF_VREF_PIN;
    xp_nxt  = 1'b0;
    xn_nxt  = 1'b0;
    yp_nxt  = 1'b0;
    yn_nxt  = 1'b0;
    if (se_r) begin
      case (chan_r)
        `CH_Y_POS: begin
          yp_nxt = drv_on;
          yn_nxt = drv_on;
        end
        `CH_Z1, `CH_Z2: begin
          xn_nxt = drv_on;
          yp_nxt = drv_on;
        end
        `CH_X_POS: begin
          xp_nxt = drv_on;
          xn_nxt = drv_on;
        end
        default: begin
          xp_nxt = 1'b0;
        end
      endcase
    end else begin
      // references always from a plate pair, never the vref pin
      case (chan_r)
        `CH_Y_POS: begin
          ref_nxt = `REF_YP_YN;
          yp_nxt  = drv_on;
          yn_nxt  = drv_on;
        end
        `CH_Z1, `CH_Z2: begin
          ref_nxt = `REF_YP_XN;
          yp_nxt  = drv_on;
          xn_nxt  = drv_on;
        end
        `CH_X_POS: begin
          ref_nxt = `REF_XP_XN;
          xp_nxt  = drv_on;
          xn_nxt  = drv_on;
        end
        default: begin
          // unsupported code: plates idle, still no vref pin
          ref_nxt = `REF_YP_YN;
        end
      endcase
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mux_sel              <= `CH_TEMP_LOW;
      ref_sel              <= `REF_VREF_PIN;
      drv_xp               <= 1'b0;
      drv_xn               <= 1'b0;
      drv_yp               <= 1'b0;
      drv_yn               <= 1'b0;
      diode_temp_low_bias  <= 1'b0;
      diode_temp_high_bias <= 1'b0;
      bat_div_en           <= 1'b0;
      sample_en            <= 1'b0;
      adc_power_down       <= 1'b1;
      dout_oe              <= 1'b0;
      busy_oe              <= 1'b0;
      busy                 <= 1'b0;
    end else begin
      mux_sel              <= mux_nxt;
      ref_sel              <= ref_nxt;
      drv_xp               <= xp_nxt;
      drv_xn               <= xn_nxt;
      drv_yp               <= yp_nxt;
      drv_yn               <= yn_nxt;
      // bias current costs power, so only while acquiring
      diode_temp_low_bias  <= acq_on & se_r & (chan_r == `CH_TEMP_LOW);
      diode_temp_high_bias <= acq_on & se_r &
                              (chan_r == `CH_TEMP_HIGH);
      bat_div_en           <= acq_on & se_r & (chan_r == `CH_BATTERY);
      sample_en            <= acq_on;
      adc_power_down       <= csn_s |
                              ((st_r == `ST_IDLE) & ~pd0_r);
      dout_oe              <= ~csn_s;
      busy_oe              <= ~csn_s;
      busy                 <= ~csn_s & (st_r == `ST_CONV);
    end
  end

  // command capture and successive approximation sequencer
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_d_r            <= 1'b0;
      st_r               <= `ST_IDLE;
      cnt_r              <= `CNT_RESET;
      cmd_r              <= `CMD_RESET;
      chan_r             <= `CH_TEMP_LOW;
      se_r               <= 1'b0;
      mode8_r            <= 1'b0;
      pd0_r              <= 1'b0;
      internal_ref_power <= 1'b0;
      idx_r              <= `SAR_MSB;
      dac_code           <= `SAR_ZERO;
      result             <= `SAR_ZERO;
      result_valid       <= 1'b0;
      dout               <= 1'b0;
    end else begin
      clk_d_r      <= clk_s;
      result_valid <= 1'b0;
      if (csn_s) begin
        // deselect aborts any frame; latched mode settings persist
        st_r  <= `ST_IDLE;
        cnt_r <= `CNT_RESET;
        dout  <= 1'b0;
      end else begin
        case (st_r)
          `ST_IDLE: begin
            if (rise && din_s) begin
              st_r  <= `ST_CMD;
              cnt_r <= `CNT_RESET;
            end
          end
          `ST_CMD: begin
            if (rise) begin
              cmd_r <= cmd_nxt;
              cnt_r <= cnt_r + 3'd1;
              if (cnt_r == `CMD_LAST) begin
                st_r               <= `ST_ACQ;
                cnt_r              <= `CNT_RESET;
                chan_r             <= cmd_nxt[`CMD_CHAN_HI:`CMD_CHAN_LO];
                mode8_r            <= cmd_nxt[`CMD_MODE_8BIT];
                se_r               <= cmd_nxt[`CMD_REF_SE];
                internal_ref_power <= cmd_nxt[`CMD_REF_PWR];
                pd0_r              <= cmd_nxt[`CMD_PD_CTRL];
              end
            end
          end
          `ST_ACQ: begin
            if (rise) begin
              cnt_r <= cnt_r + 3'd1;
              if (cnt_r == `ACQ_LAST) begin
                st_r     <= `ST_CONV;
                cnt_r    <= `CNT_RESET;
                idx_r    <= `SAR_MSB;
                dac_code <= `SAR_TRIAL;
              end
            end
          end
          `ST_CONV: begin
            if (fall) begin
              // decided bit idx_r weighs 2^idx_r steps of 1/4096 of the reference
              dac_code[idx_r] <= comp_s;
              dout            <= comp_s;
              if (idx_r == lsb_idx) begin
                st_r         <= `ST_IDLE;
                result       <= dac_code;
                result[idx_r] <= comp_s;
                result_valid <= 1'b1;
              end else begin
                dac_code[idx_r - 4'd1] <= 1'b1;
                idx_r                  <= idx_r - 4'd1;
              end
            end
          end
          default: begin
            st_r <= `ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// *** sim/touch_adc_mux_control_props.sv ***
`timescale 1ns/1ps
module touch_adc_mux_control_props (
  input wire        core_clk,
  input wire        rst,
  input wire        conversion_clock,
  input wire        cs_n,
  input wire        dout,
  input wire        dout_oe,
  input wire        busy,
  input wire        busy_oe,
  input wire [2:0]  mux_sel,
  input wire        diode_temp_low_bias,
  input wire        diode_temp_high_bias,
  input wire        bat_div_en,
  input wire        adc_power_down,
  input wire        sample_en,
  input wire [11:0] dac_code,
  input wire        result_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // four cycles covers the pin synchroniser plus the output register
  a_dout_float_off: assert property (cs_n [*4] |-> !dout_oe)
    else $error("dout driven while deselected");
  a_busy_float_off: assert property (cs_n [*4] |-> !busy_oe)
    else $error("busy driven while deselected");
  a_deselect_power_down: assert property (cs_n [*4] |-> adc_power_down)
    else $error("converter awake while deselected");
  a_dout_low_phase: assert property ($changed(dout) |-> !conversion_clock)
    else $error("dout moved outside the low clock phase");
  a_low_bias_acq: assert property (diode_temp_low_bias |->
    sample_en && mux_sel == 3'h0)
    else $error("low diode bias outside acquisition");
  a_high_bias_acq: assert property (diode_temp_high_bias |->
    sample_en && mux_sel == 3'h7)
    else $error("high diode bias outside acquisition");
  a_divider_battery_only: assert property (bat_div_en |->
    sample_en && mux_sel == 3'h2)
    else $error("battery divider on outside battery sampling");
  a_sar_first_trial: assert property ($rose(busy) |-> dac_code == 12'h800)
    else $error("conversion did not start at mid scale");
  a_valid_one_cycle: assert property (result_valid |=> !result_valid)
    else $error("result_valid wider than one cycle");
  c_result: cover property (result_valid);
  c_battery: cover property (bat_div_en);
  c_high_bias: cover property (diode_temp_high_bias);
endmodule
bind touch_adc_mux_control touch_adc_mux_control_props i_props (
  .core_clk, .rst, .conversion_clock, .cs_n, .dout, .dout_oe, .busy,
  .busy_oe, .mux_sel, .diode_temp_low_bias, .diode_temp_high_bias,
  .bat_div_en, .adc_power_down, .sample_en, .dac_code, .result_valid);

// *** sim/host_link.sv ***
`timescale 1ns/1ps
module host_link (
  input  wire core_clk,
  input  wire dout,
  output reg  conversion_clock,
  output reg  cs_n,
  output reg  din
);
  localparam H = 5; // core_clk per clock level, above the 4 needed
  initial begin
    conversion_clock = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // start bit, 7 command bits, acquisition, then 12 result bits
  task xfer(input [6:0] cmd, output [11:0] rx);
    integer k;
    reg [7:0] frame;
    begin
      rx = 12'h000;
      frame = {1'b1, cmd};
      cs_n <= 1'b0;
      repeat (H) @(posedge core_clk);
      for (k = 1; k <= 22; k = k + 1) begin
        din <= (k <= 8) ? frame[8-k] : 1'b0;
        repeat (H) @(posedge core_clk);
        if (k >= 12)
          rx = {rx[10:0], dout};
        conversion_clock <= 1'b1;
        repeat (H) @(posedge core_clk);
        conversion_clock <= 1'b0;
      end
      repeat (H) @(posedge core_clk);
      rx = {rx[10:0], dout};
    end
  endtask
  // clock stands low between frames; din no longer holds its value
  task release_link;
    begin
      cs_n <= 1'b1;
      din <= ~din;
      repeat (8) @(posedge core_clk);
    end
  endtask
endmodule

// *** sim/touch_adc_mux_control_tb.sv ***
`timescale 1ns/1ps
module touch_adc_mux_control_tb;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [11:0] ain = 12'h000;
  wire        conversion_clock, cs_n, din, dout, dout_oe, busy, busy_oe;
  wire        drv_xp, drv_xn, drv_yp, drv_yn, internal_ref_power;
  wire        adc_power_down;
  wire [2:0]  mux_sel;
  wire [1:0]  ref_sel;
  wire [11:0] dac_code, result;
  wire        comp_in = (ain >= dac_code);
  integer     mismatches = 0;
  integer     comparisons = 0;
  integer     c;
  always #20 core_clk = ~core_clk;
  host_link i_host_link (.core_clk(core_clk), .dout(dout),
    .conversion_clock(conversion_clock), .cs_n(cs_n), .din(din));
  touch_adc_mux_control i_touch_adc_mux_control (.core_clk(core_clk),
    .rst(rst), .conversion_clock(conversion_clock), .cs_n(cs_n),
    .din(din), .comp_in(comp_in), .dout(dout), .dout_oe(dout_oe),
    .busy(busy), .busy_oe(busy_oe), .mux_sel(mux_sel), .ref_sel(ref_sel),
    .drv_xp(drv_xp), .drv_xn(drv_xn), .drv_yp(drv_yp), .drv_yn(drv_yn),
    .diode_temp_low_bias(), .diode_temp_high_bias(), .bat_div_en(),
    .internal_ref_power(internal_ref_power),
    .adc_power_down(adc_power_down), .sample_en(), .dac_code(dac_code),
    .result(result), .result_valid());
  task check(input string name, input [11:0] exp, input [11:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
    end
  endtask
  // order {xp, xn, yp, yn}; same pairs in both reference modes
  function [3:0] drv_exp(input [2:0] ch);
    case (ch)
      3'h1: drv_exp = 4'b0011;
      3'h3, 3'h4: drv_exp = 4'b0110;
      3'h5: drv_exp = 4'b1100;
      default: drv_exp = 4'b0000;
    endcase
  endfunction
  function [1:0] ref_exp(input [2:0] ch);
    case (ch)
      3'h3, 3'h4: ref_exp = 2'h2;
      3'h5: ref_exp = 2'h3;
      default: ref_exp = 2'h1;
    endcase
  endfunction
  task conv(input [2:0] ch, input m8, input se, input rp, input pd);
    reg [11:0] rx;
    reg [11:0] want;
    begin
      ain <= {ch, 9'h0a5} ^ {se, 11'h3c1};
      i_host_link.xfer({ch, m8, se, rp, pd}, rx);
      repeat (6) @(posedge core_clk);
      // short mode keeps only the upper eight result bits
      want = m8 ? {ain[11:4], 4'h0} : ain;
      check("dout", want, m8 ? {rx[11:4], 4'h0} : rx);
      check("result", want, result);
      check("busy", 1'b0, busy);
      check("mux_sel", ch, mux_sel);
      check("ref_sel", se ? 2'h0 : ref_exp(ch), ref_sel);
      check("drivers", pd ? drv_exp(ch) : 4'h0,
        {drv_xp, drv_xn, drv_yp, drv_yn});
      check("ref_power", rp, internal_ref_power);
      check("power_down", !pd, adc_power_down);
      check("dout_oe", 1'b1, dout_oe);
      i_host_link.release_link();
      check("dout_oe", 1'b0, dout_oe);
      check("busy_oe", 1'b0, busy_oe);
      check("power_down", 1'b1, adc_power_down);
      $display("test ch %0d se %0d pd %0d done", ch, se, pd);
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    conv(3'h6, 1'b0, 1'b1, 1'b0, 1'b0);
    for (c = 0; c < 8; c = c + 1)
      conv(c[2:0], 1'b0, 1'b1, c[0], 1'b1);
    for (c = 0; c < 8; c = c + 1)
      conv(c[2:0], 1'b0, 1'b0, 1'b0, c != 2);
    conv(3'h5, 1'b1, 1'b0, 1'b0, 1'b1);
    tally_and_finish;
  end
endmodule
